// *** src/pdr_pkg.sv ***
// Purpose: shared constants and types of the pcm dma, interrupt and strobe receive control slice
// Assumes: 32-bit classic wishbone register port, fifo levels on the system clock
// Notes: byte offsets are word aligned
package pdr_pkg;

   // fifo level and threshold width
   localparam int unsigned LVL_W = 7;
   localparam int unsigned WORD_BITS = 32;
   localparam int unsigned CNT_W = 6;

   // register byte offsets
   localparam logic [7:0] ADR_DMA_THR = 8'h00;
   localparam logic [7:0] ADR_INT_EN = 8'h04;
   localparam logic [7:0] ADR_INT_STAT = 8'h08;
   localparam logic [7:0] ADR_STROBE = 8'h0c;
   localparam logic [7:0] ADR_IRQ_THR = 8'h10;

   // dma threshold fields
   localparam int unsigned TXPAN_LSB = 24;
   localparam int unsigned RXPAN_LSB = 16;
   localparam int unsigned TXREQ_LSB = 8;
   localparam int unsigned RXREQ_LSB = 0;
   localparam logic [31:0] DMA_THR_MASK = 32'h7f7f7f7f;
   localparam logic [31:0] DMA_THR_RST = 32'h10303020;

   // interrupt threshold fields
   localparam int unsigned TX_IRQ_THRESHOLD_LSB = 0;
   localparam int unsigned RX_IRQ_THRESHOLD_LSB = 8;
   localparam logic [31:0] IRQ_THR_MASK = 32'h00007f7f;
   localparam logic [31:0] IRQ_THR_RST = 32'h00002020;

   // interrupt enable and status bits
   localparam int unsigned ST_TXW = 0;
   localparam int unsigned ST_RXR = 1;
   localparam int unsigned ST_TX_FIFO_FAULT = 2;
   localparam int unsigned ST_RX_FIFO_FAULT = 3;
   localparam logic [3:0] INT_RST = 4'h0;

   // strobe mode control fields
   localparam int unsigned SC_EN = 0;
   localparam int unsigned SC_CLR = 1;
   localparam int unsigned SC_FLUSH = 2;
   localparam int unsigned RXBUF_LSB = 4;
   localparam int unsigned FLUSHED_LSB = 10;
   localparam int unsigned RXQ_LSB = 16;

   // strobe receiver states, gray coded
   typedef enum logic [1:0]
   {
      SRX_IDLE = 2'b00,
      SRX_RUN = 2'b01
   } pdr_srx_mode_type;

   // true when level a is strictly below level b
   function automatic logic pdr_below(input logic [LVL_W-1:0] a, input logic [LVL_W-1:0] b);
      return a < b;
   endfunction : pdr_below

endpackage : pdr_pkg

// *** src/pdr_srx_if.sv ***
// Purpose: link between the control registers and the strobe receiver
// Assumes: one clock, all signals registered at their source
// Notes: flush_req is a level held until done pulses
`timescale 1ns/1ns
interface pdr_srx_if;
   logic en;
   logic clr;
   logic flush_req;
   logic done;
   logic [5:0] fill;
   logic [5:0] flushed;
   logic wr;
   logic [31:0] wdata;

   modport ctrl (output en, output clr, output flush_req, input done, input fill, input flushed,
      input wr, input wdata);
   modport rx (input en, input clr, input flush_req, output done, output fill, output flushed,
      output wr, output wdata);
endinterface : pdr_srx_if

// *** src/pdr_strobe_rx.sv ***
// Purpose: data/strobe receive buffer packing bits into 32-bit words
// Assumes: data and strobe pins asynchronous, far slower than clk_i
// Notes: first received bit lands in bit 0
`timescale 1ns/1ns
module pdr_strobe_rx
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic strobe_data_i,
   input wire logic strobe_sync_i,
   pdr_srx_if.rx srx
);
   import pdr_pkg::*;

   typedef struct packed
   {
      logic [1:0] meta;
      logic [1:0] pin;
      logic par;
      pdr_srx_mode_type mode;
      logic [31:0] shift;
      logic [5:0] cnt;
      logic [5:0] flushed;
      logic wr;
      logic [31:0] wdata;
      logic done;
   } pdr_srx_state_type;

   pdr_srx_state_type s_reg;
   pdr_srx_state_type s_next;
   logic bit_edge;
   logic [31:0] with_bit;

   // a new bit shows as a change of data xor strobe
   assign bit_edge = (s_reg.pin[0] ^ s_reg.pin[1]) != s_reg.par;
   assign with_bit = s_reg.shift | ({31'h0, s_reg.pin[0]} << s_reg.cnt);

   // next state of the receiver
   always_comb
   begin
      s_next = s_reg;
      s_next.meta = {strobe_sync_i, strobe_data_i};
      s_next.pin = s_reg.meta;
      s_next.par = s_reg.pin[0] ^ s_reg.pin[1];
      s_next.wr = 1'b0;
      s_next.done = 1'b0;
      if (srx.clr || !srx.en)
      begin
         // held in reset, buffer discarded, a pending flush ends empty
         s_next.mode = SRX_IDLE;
         s_next.shift = 32'h0;
         s_next.cnt = 6'h0;
         s_next.flushed = srx.clr ? 6'h0 : s_reg.flushed;
         s_next.done = srx.flush_req && !s_reg.done;
      end
      else
      begin
         case (s_reg.mode)
            SRX_IDLE:
            begin
               s_next.mode = SRX_RUN;
            end
            default:
            begin
               if (bit_edge)
               begin
                  // store the bit and count it
                  s_next.shift = with_bit;
                  s_next.cnt = s_reg.cnt + 6'h1;
                  if (s_reg.cnt == 6'(WORD_BITS - 1))
                  begin
                     s_next.wr = 1'b1;
                     s_next.wdata = with_bit;
                     s_next.shift = 32'h0;
                     s_next.cnt = 6'h0;
                  end
               end
               else if (srx.flush_req && !s_reg.done)
               begin
                  // early write of a partial word, zero filled above
                  s_next.wr = s_reg.cnt != 6'h0;
                  s_next.wdata = s_reg.shift;
                  s_next.flushed = s_reg.cnt;
                  s_next.shift = 32'h0;
                  s_next.cnt = 6'h0;
                  s_next.done = 1'b1;
               end
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_reg <= '{meta: 2'h0, pin: 2'h0, par: 1'b0, mode: SRX_IDLE, shift: 32'h0, cnt: 6'h0,
            flushed: 6'h0, wr: 1'b0, wdata: 32'h0, done: 1'b0};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state register
   assign srx.done = s_reg.done;
   assign srx.fill = s_reg.cnt;
   assign srx.flushed = s_reg.flushed;
   assign srx.wr = s_reg.wr;
   assign srx.wdata = s_reg.wdata;

endmodule : pdr_strobe_rx

// *** src/pdr_ctrl.sv ***
// Purpose: dma request and panic levels, interrupt status and strobe receive control
// Assumes: fifo levels and fault pulses come from logic on clk_i
// Notes: registers over classic wishbone, ack one cycle after the request
//
// Contract
// - two dma sets, transmit and receive
// - tx panic when tx level below threshold
// - rx panic when rx level above threshold
// - tx request when tx level below threshold
// - rx request when rx level above threshold
// - enable bits for rx and tx errors
// - rx read event when level at or above threshold
// - tx write event when level below threshold
// - four latched status bits
// - write one clears status, zero keeps
// - report receive fifo word count
// - count buffered bits, write full words
// - flush writes partial buffer early
// - flushed word zero filled from bit zero
// - flush bit reads zero until done
// - record valid bits of last flush
// - clear bit holds strobe logic reset
// - enable bit selects strobe mode
`timescale 1ns/1ns
module pdr_ctrl
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [pdr_pkg::LVL_W-1:0] tx_fill_i,
   input wire logic [pdr_pkg::LVL_W-1:0] rx_fill_i,
   input wire logic tx_fifo_fault_i,
   input wire logic rx_fifo_fault_i,
   input wire logic strobe_data_i,
   input wire logic strobe_sync_i,
   output logic tx_dreq_o,
   output logic tx_panic_o,
   output logic rx_dreq_o,
   output logic rx_panic_o,
   output logic irq_o,
   output logic strobe_mode_o,
   output logic rx_fifo_wr_o,
   output logic [31:0] rx_fifo_wdata_o
);
   import pdr_pkg::*;

   // all control state of the slice
   typedef struct packed
   {
      logic ack;
      logic [31:0] rdata;
      logic [31:0] dma_thr;
      logic [31:0] irq_thr;
      logic [3:0] int_en;
      logic [3:0] status;
      logic strobe_en;
      logic strobe_clr;
      logic flush_pend;
      logic [5:0] rxq;
      logic tx_dreq;
      logic tx_panic;
      logic rx_dreq;
      logic rx_panic;
      logic irq;
   } pdr_ctrl_state_type;

   pdr_ctrl_state_type s_reg;
   pdr_ctrl_state_type s_next;

   pdr_srx_if srx();

   // threshold fields of the stored words
   logic [LVL_W-1:0] tx_pan_lvl;
   logic [LVL_W-1:0] rx_pan_lvl;
   logic [LVL_W-1:0] tx_req_lvl;
   logic [LVL_W-1:0] rx_req_lvl;
   logic [LVL_W-1:0] tx_irq_threshold;
   logic [LVL_W-1:0] rx_irq_threshold;

   // bus handshake terms
   logic req;
   logic wr_now;
   logic [31:0] rd_word;
   logic [3:0] st_set;
   logic [3:0] st_clr;

   // merge a write into a stored word under the byte lanes and a field mask
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
      input logic [3:0] sel, input logic [31:0] mask);
      logic [31:0] bm;
      bm = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & mask;
      return (old & ~bm) | (wd & bm);
   endfunction : lane_merge

   // field extraction
   assign tx_pan_lvl = s_reg.dma_thr[TXPAN_LSB +: LVL_W];
   assign rx_pan_lvl = s_reg.dma_thr[RXPAN_LSB +: LVL_W];
   assign tx_req_lvl = s_reg.dma_thr[TXREQ_LSB +: LVL_W];
   assign rx_req_lvl = s_reg.dma_thr[RXREQ_LSB +: LVL_W];
   assign tx_irq_threshold = s_reg.irq_thr[TX_IRQ_THRESHOLD_LSB +: LVL_W];
   assign rx_irq_threshold = s_reg.irq_thr[RX_IRQ_THRESHOLD_LSB +: LVL_W];

   // a new request is taken while ack is low; a write lands when ack is high
   assign req = wb_cyc_i && wb_stb_i && !s_reg.ack;
   assign wr_now = wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack;

   // read data mux
   always_comb
   begin
      rd_word = 32'h0;
      if (wb_adr_i == ADR_DMA_THR)
      begin
         rd_word = s_reg.dma_thr;
      end
      else if (wb_adr_i == ADR_INT_EN)
      begin
         rd_word = {28'h0, s_reg.int_en};
      end
      else if (wb_adr_i == ADR_INT_STAT)
      begin
         rd_word = {28'h0, s_reg.status};
      end
      else if (wb_adr_i == ADR_STROBE)
      begin
         // flush bit always reads as zero while pending and after
         rd_word[SC_EN] = s_reg.strobe_en;
         rd_word[SC_CLR] = s_reg.strobe_clr;
         rd_word[SC_FLUSH] = 1'b0;
         rd_word[RXBUF_LSB +: CNT_W] = srx.fill;
         rd_word[FLUSHED_LSB +: CNT_W] = srx.flushed;
         rd_word[RXQ_LSB +: CNT_W] = s_reg.rxq;
      end
      else if (wb_adr_i == ADR_IRQ_THR)
      begin
         rd_word = s_reg.irq_thr;
      end
   end

   // interrupt events raised only for enabled causes
   always_comb
   begin
      st_set = 4'h0;
      st_set[ST_TXW] = s_reg.int_en[ST_TXW] && pdr_below(tx_fill_i, tx_irq_threshold);
      st_set[ST_RXR] = s_reg.int_en[ST_RXR] && !pdr_below(rx_fill_i, rx_irq_threshold);
      st_set[ST_TX_FIFO_FAULT] = s_reg.int_en[ST_TX_FIFO_FAULT] && tx_fifo_fault_i;
      st_set[ST_RX_FIFO_FAULT] = s_reg.int_en[ST_RX_FIFO_FAULT] && rx_fifo_fault_i;
   end

   // write one clears a status bit, write zero keeps it
   always_comb
   begin
      st_clr = 4'h0;
      if (wr_now && wb_adr_i == ADR_INT_STAT && wb_sel_i[0])
      begin
         st_clr = wb_dat_i[3:0];
      end
   end

   // next state of the control slice
   always_comb
   begin
      s_next = s_reg;
      s_next.ack = req;
      if (req)
      begin
         s_next.rdata = wb_we_i ? 32'h0 : rd_word;
      end
      if (wr_now)
      begin
         // software keeps these stable while running
         if (wb_adr_i == ADR_DMA_THR)
         begin
            s_next.dma_thr = lane_merge(s_reg.dma_thr, wb_dat_i, wb_sel_i, DMA_THR_MASK);
         end
         else if (wb_adr_i == ADR_INT_EN)
         begin
            s_next.int_en = 4'(lane_merge({28'h0, s_reg.int_en}, wb_dat_i, wb_sel_i, 32'hf));
         end
         else if (wb_adr_i == ADR_IRQ_THR)
         begin
            s_next.irq_thr = lane_merge(s_reg.irq_thr, wb_dat_i, wb_sel_i, IRQ_THR_MASK);
         end
         else if (wb_adr_i == ADR_STROBE && wb_sel_i[0])
         begin
            s_next.strobe_en = wb_dat_i[SC_EN];
            s_next.strobe_clr = wb_dat_i[SC_CLR];
            if (wb_dat_i[SC_FLUSH])
            begin
               s_next.flush_pend = 1'b1;
            end
         end
      end
      // completion ends the flush unless a new one is written now
      if (srx.done && !(wr_now && wb_adr_i == ADR_STROBE && wb_sel_i[0] && wb_dat_i[SC_FLUSH]))
      begin
         s_next.flush_pend = 1'b0;
      end
      // a set in the same cycle as its clear wins
      s_next.status = (s_reg.status & ~st_clr) | st_set;
      s_next.rxq = rx_fill_i[CNT_W-1:0];
      // two independent dma sets
      s_next.tx_panic = pdr_below(tx_fill_i, tx_pan_lvl);
      s_next.rx_panic = pdr_below(rx_pan_lvl, rx_fill_i);
      s_next.tx_dreq = pdr_below(tx_fill_i, tx_req_lvl);
      s_next.rx_dreq = pdr_below(rx_req_lvl, rx_fill_i);
      s_next.irq = |(s_next.status & s_next.int_en);
   end

   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_reg <= '{ack: 1'b0, rdata: 32'h0, dma_thr: DMA_THR_RST, irq_thr: IRQ_THR_RST,
            int_en: INT_RST, status: INT_RST, strobe_en: 1'b0, strobe_clr: 1'b0,
            flush_pend: 1'b0, rxq: 6'h0, tx_dreq: 1'b0, tx_panic: 1'b0, rx_dreq: 1'b0,
            rx_panic: 1'b0, irq: 1'b0};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // control toward the strobe receiver
   assign srx.en = s_reg.strobe_en;
   assign srx.clr = s_reg.strobe_clr;
   assign srx.flush_req = s_reg.flush_pend;

   // strobe mode receive buffer
   pdr_strobe_rx u_srx
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .strobe_data_i(strobe_data_i),
      .strobe_sync_i(strobe_sync_i),
      .srx(srx)
   );

   // outputs, each from a flip-flop
   assign wb_dat_o = s_reg.rdata;
   assign wb_ack_o = s_reg.ack;
   assign tx_dreq_o = s_reg.tx_dreq;
   assign tx_panic_o = s_reg.tx_panic;
   assign rx_dreq_o = s_reg.rx_dreq;
   assign rx_panic_o = s_reg.rx_panic;
   assign irq_o = s_reg.irq;
   assign strobe_mode_o = s_reg.strobe_en;
   assign rx_fifo_wr_o = srx.wr;
   assign rx_fifo_wdata_o = srx.wdata;

endmodule : pdr_ctrl

// *** verification/pdr_dma_model.sv ***
// Purpose: dma controller model moving words in and out of the fifos
// Assumes: levels loaded by the bench while stopped
// Notes: panic doubles the transfer rate
`timescale 1ns/1ns
module pdr_dma_model
(
   input wire logic clk_i,
   input wire logic load_i,
   input wire logic run_i,
   input wire logic [pdr_pkg::LVL_W-1:0] tx_set_i,
   input wire logic [pdr_pkg::LVL_W-1:0] rx_set_i,
   input wire logic tx_dreq_i,
   input wire logic tx_panic_i,
   input wire logic rx_dreq_i,
   input wire logic rx_panic_i,
   input wire logic wr_i,
   output logic [pdr_pkg::LVL_W-1:0] tx_fill_o,
   output logic [pdr_pkg::LVL_W-1:0] rx_fill_o
);
   import pdr_pkg::*;
   initial
   begin
      tx_fill_o = '0;
      rx_fill_o = '0;
   end
   // fifo levels as words are moved
   always @(posedge clk_i)
   begin
      if (load_i)
      begin
         tx_fill_o <= tx_set_i;
         rx_fill_o <= rx_set_i;
      end
      else if (run_i)
      begin
         tx_fill_o <= tx_fill_o + LVL_W'(tx_dreq_i) + LVL_W'(tx_panic_i);
         rx_fill_o <= rx_fill_o - LVL_W'(rx_dreq_i) - LVL_W'(rx_panic_i) + LVL_W'(wr_i);
      end
      else
         rx_fill_o <= rx_fill_o + LVL_W'(wr_i);
   end
endmodule : pdr_dma_model

// *** verification/pdr_ctrl_assertions.sv ***
// Purpose: port checks of the control slice
// Assumes: threshold writes use all byte lanes
// Notes: bound to pdr_ctrl
`timescale 1ns/1ns
module pdr_ctrl_assertions
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [pdr_pkg::LVL_W-1:0] tx_fill_i,
   input wire logic [pdr_pkg::LVL_W-1:0] rx_fill_i,
   input wire logic tx_dreq_o,
   input wire logic tx_panic_o,
   input wire logic rx_dreq_o,
   input wire logic rx_panic_o,
   input wire logic strobe_mode_o,
   input wire logic rx_fifo_wr_o
);
   import pdr_pkg::*;
   logic [31:0] thr_reg;
   logic [2:0] rst_reg;
   logic wr_thr;
   // full-word write to the dma thresholds
   assign wr_thr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == ADR_DMA_THR && wb_sel_i == 4'hf;
   // threshold shadow and reset history
   always_ff @(posedge clk_i)
   begin
      rst_reg <= {rst_reg[1:0], rst_i};
      if (rst_i)
         thr_reg <= DMA_THR_RST;
      else if (wr_thr)
         thr_reg <= wb_dat_i & DMA_THR_MASK;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   AST_WR_ZERO: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
      else $error("write data not zero");
   AST_TX_PANIC: assert property (rst_reg == 3'h0 |-> tx_panic_o == ($past(tx_fill_i) < $past(thr_reg[30:24])))
      else $error("tx panic wrong");
   AST_RX_PANIC: assert property (rst_reg == 3'h0 |-> rx_panic_o == ($past(rx_fill_i) > $past(thr_reg[22:16])))
      else $error("rx panic wrong");
   AST_TX_DREQ: assert property (rst_reg == 3'h0 |-> tx_dreq_o == ($past(tx_fill_i) < $past(thr_reg[14:8])))
      else $error("tx request wrong");
   AST_RX_DREQ: assert property (rst_reg == 3'h0 |-> rx_dreq_o == ($past(rx_fill_i) > $past(thr_reg[6:0])))
      else $error("rx request wrong");
   AST_MODE_ON: assert property (wb_ack_o && wb_we_i && wb_adr_i == ADR_STROBE && wb_sel_i[0]
      && wb_dat_i[SC_EN] |-> ##[1:2] strobe_mode_o)
      else $error("strobe mode not set");
   AST_WR_PULSE: assert property (rx_fifo_wr_o |=> !rx_fifo_wr_o)
      else $error("fifo write held");
   cover property (tx_dreq_o && tx_panic_o);
   cover property (rx_dreq_o && rx_panic_o);
   cover property (rx_fifo_wr_o);
   cover property (wb_ack_o && wb_we_i && wb_adr_i == ADR_INT_STAT);
endmodule : pdr_ctrl_assertions
bind pdr_ctrl pdr_ctrl_assertions u_pdr_ctrl_assertions (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_fill_i, .rx_fill_i, .tx_dreq_o, .tx_panic_o,
   .rx_dreq_o, .rx_panic_o, .strobe_mode_o, .rx_fifo_wr_o);

// *** verification/test_pcm_dma_irq_strobe_rx_ctrl.sv ***
// Purpose: self-checking bench of the control slice
// Assumes: dma model supplies the fifo levels
// Notes: strobe pins hold each bit four clocks
`timescale 1ns/1ns
module test_pcm_dma_irq_strobe_rx_ctrl;
   import pdr_pkg::*;
   logic clk_i, rst_i, cyc, stb, we, txf, rxf, sd, ss, tog, load, run;
   logic ack, txd, txp, rxd, rxp, irq, smode, fwr;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat, q, dat_o, wdata, last_word;
   logic [LVL_W-1:0] txs, rxs, tx_fill, rx_fill;
   int fails, checked, cycles, words;
   pdr_ctrl u_pdr_ctrl (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .tx_fill_i(tx_fill),
      .rx_fill_i(rx_fill), .tx_fifo_fault_i(txf), .rx_fifo_fault_i(rxf), .strobe_data_i(sd),
      .strobe_sync_i(ss), .tx_dreq_o(txd), .tx_panic_o(txp), .rx_dreq_o(rxd), .rx_panic_o(rxp),
      .irq_o(irq), .strobe_mode_o(smode), .rx_fifo_wr_o(fwr), .rx_fifo_wdata_o(wdata));
   pdr_dma_model u_pdr_dma_model (.clk_i, .load_i(load), .run_i(run), .tx_set_i(txs), .rx_set_i(rxs),
      .tx_dreq_i(txd), .tx_panic_i(txp), .rx_dreq_i(rxd), .rx_panic_i(rxp), .wr_i(fwr),
      .tx_fill_o(tx_fill), .rx_fill_o(rx_fill));
   // clock
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // cycle limit and capture of fifo writes
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (fwr === 1'b1)
      begin
         last_word <= wdata;
         words <= words + 1;
      end
      if (cycles == 5000)
      begin
         fails = fails + 1;
         end_of_test();
      end
   end
   task end_of_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge clk_i);
      // wait for the answer; only the cycle limit ends a hang
      while (ack !== 1'b1)
      begin
         @(posedge clk_i);
      end
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : xfer
   task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(n, q, e);
   endtask : rchk
   task fill(input logic [LVL_W-1:0] t, input logic [LVL_W-1:0] r);
      load <= 1'b1;
      txs <= t;
      rxs <= r;
      @(posedge clk_i);
      load <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : fill
   task put_bits(input logic [31:0] v, input int k);
      for (int i = 0; i < k; i++)
      begin
         tog = ~tog;
         sd <= v[i];
         ss <= tog ^ v[i];
         repeat (4) @(posedge clk_i);
      end
      repeat (4) @(posedge clk_i);
   endtask : put_bits
   task pulse_fault(input logic t);
      txf <= t;
      rxf <= ~t;
      @(posedge clk_i);
      txf <= 1'b0;
      rxf <= 1'b0;
      @(posedge clk_i);
   endtask : pulse_fault
   task t_reset;
      rchk("dma thr", ADR_DMA_THR, DMA_THR_RST);
      rchk("enable", ADR_INT_EN, 32'h0);
      rchk("status", ADR_INT_STAT, 32'h0);
      rchk("strobe", ADR_STROBE, 32'h0);
   endtask : t_reset
   task t_dma;
      logic [17:0] tab [3];
      tab = '{{7'd4, 7'd9, 4'hf}, {7'd5, 7'd8, 4'h9}, {7'd7, 7'd6, 4'h0}};
      xfer(1'b1, ADR_DMA_THR, 32'hffffffff);
      rchk("dma mask", ADR_DMA_THR, DMA_THR_MASK);
      xfer(1'b1, ADR_DMA_THR, 32'h05060708);
      xfer(1'b1, 8'h20, 32'h0);
      rchk("unmapped", 8'h20, 32'h0);
      rchk("dma thr", ADR_DMA_THR, 32'h05060708);
      foreach (tab[i])
      begin
         fill(tab[i][17:11], tab[i][10:4]);
         chk("dma lines", {28'h0, txd, txp, rxd, rxp}, {28'h0, tab[i][3:0]});
      end
      fill(7'd0, 7'd16);
      run <= 1'b1;
      repeat (30) @(posedge clk_i);
      run <= 1'b0;
      chk("dma idle", {30'h0, txd, rxd}, 32'h0);
   endtask : t_dma
   task t_irq;
      fill(7'h20, 7'h1f);
      xfer(1'b1, ADR_INT_EN, 32'hf);
      rchk("edge", ADR_INT_STAT, 32'h0);
      xfer(1'b1, ADR_INT_EN, 32'h0);
      fill(7'h1f, 7'h20);
      rchk("gated", ADR_INT_STAT, 32'h0);
      xfer(1'b1, ADR_INT_EN, 32'h1);
      rchk("tx write", ADR_INT_STAT, 32'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      xfer(1'b1, ADR_INT_EN, 32'h2);
      rchk("rx read", ADR_INT_STAT, 32'h3);
      xfer(1'b1, ADR_INT_EN, 32'h0);
      xfer(1'b1, ADR_INT_STAT, 32'h1);
      xfer(1'b1, ADR_INT_STAT, 32'h0);
      rchk("clear one", ADR_INT_STAT, 32'h2);
      chk("irq off", {31'h0, irq}, 32'h0);
      xfer(1'b1, ADR_INT_STAT, 32'h2);
      xfer(1'b1, ADR_INT_EN, 32'h4);
      pulse_fault(1'b0);
      pulse_fault(1'b1);
      rchk("tx fault", ADR_INT_STAT, 32'h4);
      xfer(1'b1, ADR_INT_EN, 32'h8);
      pulse_fault(1'b0);
      rchk("rx fault", ADR_INT_STAT, 32'hc);
      rchk("enable", ADR_INT_EN, 32'h8);
      xfer(1'b1, ADR_INT_STAT, 32'hf);
      rchk("clear all", ADR_INT_STAT, 32'h0);
   endtask : t_irq
   task t_strobe;
      fill(7'd0, 7'd0);
      xfer(1'b1, ADR_STROBE, 32'h1);
      @(posedge clk_i);
      chk("mode", {31'h0, smode}, 32'h1);
      put_bits(32'hc3a50f96, 32);
      chk("words", words, 1);
      chk("word", last_word, 32'hc3a50f96);
      put_bits(32'h1d, 5);
      rchk("part", ADR_STROBE, 32'h00010051);
      xfer(1'b1, ADR_STROBE, 32'h5);
      repeat (4) @(posedge clk_i);
      chk("flush word", last_word, 32'h1d);
      rchk("flushed", ADR_STROBE, 32'h00021401);
      put_bits(32'h7, 3);
      xfer(1'b1, ADR_STROBE, 32'h3);
      put_bits(32'h1, 1);
      rchk("held", ADR_STROBE, 32'h00020003);
      xfer(1'b1, ADR_STROBE, 32'h0);
      chk("words", words, 2);
   endtask : t_strobe
   // reset, then the scenarios
   initial
   begin
      rst_i = 1'b1;
      {cyc, stb, we, txf, rxf, sd, ss, tog, run} = '0;
      load = 1'b1;
      adr = 8'h0;
      sel = 4'hf;
      dat = 32'h0;
      txs = '0;
      rxs = '0;
      {fails, checked, cycles, words} = '0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_dma();
      t_irq();
      t_strobe();
      end_of_test();
   end
endmodule : test_pcm_dma_irq_strobe_rx_ctrl
